// File: spcr_pkg.sv
// spcr_pkg: register map, field layout and carriers for the switch port config bank
// assumes one 40 MHz clock and a plain address/strobe register port
package spcr_pkg;

  // word indices of the bank, byte address is four times the index
  localparam logic [3:0] SPCR_IDX_SRCID_LO = 4'h0;
  localparam logic [3:0] SPCR_IDX_SRCID_HI = 4'h1;
  localparam logic [3:0] SPCR_IDX_HOSTBLK = 4'h2;
  localparam logic [3:0] SPCR_IDX_ADDVAL_LO = 4'h3;
  localparam logic [3:0] SPCR_IDX_ADDVAL_HI = 4'h4;
  localparam logic [3:0] SPCR_IDX_PAUSE_LO = 4'h5;
  localparam logic [3:0] SPCR_IDX_PAUSE_HI = 4'h6;
  localparam logic [3:0] SPCR_IDX_TSCTL = 4'h7;
  localparam int SPCR_ADDR_W = 6;

  // reset values
  localparam logic [31:0] SPCR_RST_SRCID_LO = 32'h04030201;
  localparam logic [31:0] SPCR_RST_SRCID_HI = 32'h08070605;
  localparam logic [31:0] SPCR_RST_ZERO = 32'h00000000;

  // writable bit masks, everything else reads zero
  localparam logic [31:0] SPCR_MASK_ADDVAL = 32'h1F1F1F1F;
  localparam logic [31:0] SPCR_MASK_PAUSE_LO = 32'h0000FFFF;
  localparam logic [31:0] SPCR_MASK_TSCTL = 32'hFFFF0FFF;
  localparam logic [4:0] SPCR_ADDVAL_MAX = 5'h0B;

  // time-sync control field positions
  localparam int SPCR_TS_MSG_LSB = 16;
  localparam int SPCR_TS_HOST_STAMP = 11;
  localparam int SPCR_TS_TX_ANNEX_E = 10;
  localparam int SPCR_TS_RX_ANNEX_E = 9;
  localparam int SPCR_TS_LT2 = 8;
  localparam int SPCR_TS_TX_ANNEX_D = 7;
  localparam int SPCR_TS_TX_VLAN2 = 6;
  localparam int SPCR_TS_TX_VLAN1 = 5;
  localparam int SPCR_TS_TX_ANNEX_F = 4;
  localparam int SPCR_TS_RX_ANNEX_D = 3;
  localparam int SPCR_TS_RX_VLAN2 = 2;
  localparam int SPCR_TS_RX_VLAN1 = 1;
  localparam int SPCR_TS_RX_ANNEX_F = 0;

  // register port request
  typedef struct packed {
    logic [SPCR_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } spcr_req_s;

  // per-direction time-sync decode enables
  typedef struct packed {
    logic [15:0] msg_kind_en;
    logic annex_e;
    logic annex_d;
    logic vlan_type2;
    logic vlan_type1;
    logic annex_f;
    logic second_length_type;
  } spcr_ts_dir_s;

  // received frame descriptor from the datapath
  typedef struct packed {
    logic valid;
    logic [2:0] port_idx;
  } spcr_rx_s;

  // pause frame source address insertion
  typedef struct packed {
    logic valid;
    logic [47:0] src_addr;
  } spcr_pause_s;

endpackage : spcr_pkg

// File: spcr_regs.sv
// spcr_regs: per-port configuration registers of the gigabit switch
// assumes the datapath flags rx frames and pause frame slots in the clk_sys domain
// Behaviour
// RULE_01 - rx frame on port k gets port k source id; ids reset to k
// RULE_02 - ports 1-4 in first word, 5-8 in second, low port lowest byte
// RULE_03 - eight 4-bit host block counts, priority p at bits 4p+3:4p, reset zero
// RULE_04 - software keeps each 5-bit outflow add value at eleven or below
// RULE_05 - pause address goes only into transmitted pause frames
// RULE_06 - low pause word: byte0 at 15:8, byte1 at 7:0, upper half reserved
// RULE_07 - high pause word: bytes 2,3,4,5 at 31:24,23:16,15:8,7:0, reset zero
// RULE_08 - message kind enable bit i admits type i both directions
// RULE_09 - rx decode enables: annex E 9, D 3, vlan2 2, vlan1 1, F 0
// RULE_10 - tx decode enables: annex E 10, D 7, vlan2 6, vlan1 5, F 4
// RULE_11 - one second-length-type enable at bit 8 serves tx and rx
// RULE_12 - tx host time stamp enable at bit 11, reset zero
// RULE_13 - reserved bits read zero and ignore writes
`timescale 1ns/1ps
module spcr_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register port
  input wire spcr_pkg::spcr_req_s req,
  output logic [31:0] rdata,
  // receive source id lookup
  input wire spcr_pkg::spcr_rx_s rx_in,
  output logic [7:0] packet_source_identifier,
  output logic packet_source_identifier_valid,
  // pause frame address insertion
  input wire logic pause_frame_slot,
  output spcr_pkg::spcr_pause_s pause_out,
  // configuration towards the datapath
  output logic [31:0] host_block_count_prio,
  output logic [39:0] outflow_increment_prio,
  output spcr_pkg::spcr_ts_dir_s ts_rx,
  output spcr_pkg::spcr_ts_dir_s ts_tx,
  output logic tx_host_stamp_enable
);
  import spcr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // storage: one flip-flop word per register, indexed
  localparam int NREG = 8;
  logic [31:0] regs_q [NREG];
  logic [31:0] regs_d [NREG];
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // writable mask per index, reserved lanes stay zero
  function automatic logic [31:0] wmask(input logic [3:0] idx);
    case (idx)
      SPCR_IDX_ADDVAL_LO, SPCR_IDX_ADDVAL_HI: wmask = SPCR_MASK_ADDVAL;
      SPCR_IDX_PAUSE_LO: wmask = SPCR_MASK_PAUSE_LO;
      SPCR_IDX_TSCTL: wmask = SPCR_MASK_TSCTL;
      default: wmask = 32'hFFFFFFFF;
    endcase
  endfunction : wmask

  // word-aligned decode; unmapped or unaligned reads give zero
  function automatic logic hit(input logic [SPCR_ADDR_W-1:0] a);
    hit = (a[1:0] == 2'h0) && (a[SPCR_ADDR_W-1:2] < 4'h8);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // next-state of the register file and the read data
  logic [3:0] widx;
  always_comb begin
    widx = {1'b0, req.addr[4:2]};
    for (int i = 0; i < NREG; i++) begin
      regs_d[i] = regs_q[i];
    end
    // masked store keeps reserved bits at zero
    if (req.wr && hit(req.addr)) begin
      regs_d[widx[2:0]] = req.wdata & wmask(widx); // RULE_13
    end
    rdata_d = 32'h00000000;
    if (req.rd && hit(req.addr)) begin
      rdata_d = regs_q[widx[2:0]];
    end
  end

  // register process only; id words reset to their port numbers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= SPCR_RST_ZERO; // RULE_03 RULE_07 RULE_12
      end
      regs_q[SPCR_IDX_SRCID_LO[2:0]] <= SPCR_RST_SRCID_LO; // RULE_01 RULE_02
      regs_q[SPCR_IDX_SRCID_HI[2:0]] <= SPCR_RST_SRCID_HI; // RULE_02
      rdata_q <= 32'h00000000;
    end else begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= regs_d[i];
      end
      rdata_q <= rdata_d;
    end
  end
  assign rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // source id stamped into info word 0 of each received frame
  logic [7:0] srcid_q;
  logic [7:0] srcid_d;
  logic srcid_v_q;
  logic srcid_v_d;
  logic [63:0] ids_all;
  always_comb begin
    // port k sits at byte k-1 across the two words
    ids_all = {regs_q[SPCR_IDX_SRCID_HI[2:0]], regs_q[SPCR_IDX_SRCID_LO[2:0]]}; // RULE_02
    srcid_v_d = rx_in.valid;
    srcid_d = rx_in.valid ? ids_all[rx_in.port_idx*8 +: 8] : srcid_q; // RULE_01
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      srcid_q <= 8'h00;
      srcid_v_q <= 1'b0;
    end else begin
      srcid_q <= srcid_d;
      srcid_v_q <= srcid_v_d;
    end
  end
  assign packet_source_identifier = srcid_q;
  assign packet_source_identifier_valid = srcid_v_q;

  ////////////////////////////////////////////////////////////////////////////
  // pause address: driven only on pause slots, zero otherwise so it cannot leak
  spcr_pause_s pause_q;
  spcr_pause_s pause_d;
  logic [31:0] plo;
  logic [31:0] phi;
  always_comb begin
    plo = regs_q[SPCR_IDX_PAUSE_LO[2:0]];
    phi = regs_q[SPCR_IDX_PAUSE_HI[2:0]];
    pause_d.valid = pause_frame_slot; // RULE_05
    pause_d.src_addr = 48'h000000000000;
    if (pause_frame_slot) begin
      // byte0 is first on the wire; bytes packed byte5..byte0
      pause_d.src_addr = {phi[7:0], phi[15:8], phi[23:16], phi[31:24], // RULE_07
                          plo[7:0], plo[15:8]}; // RULE_06
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pause_q <= '0;
    end else begin
      pause_q <= pause_d;
    end
  end
  assign pause_out = pause_q;

  ////////////////////////////////////////////////////////////////////////////
  // configuration fan-out, registered so outputs come from flip-flops
  logic [31:0] hb_q;
  logic [39:0] av_q;
  spcr_ts_dir_s rx_q;
  spcr_ts_dir_s tx_q;
  logic hts_q;
  logic [31:0] hb_d;
  logic [39:0] av_d;
  spcr_ts_dir_s rx_d;
  spcr_ts_dir_s tx_d;
  logic hts_d;
  logic [31:0] ts;
  logic [31:0] avl;
  logic [31:0] avh;
  always_comb begin
    ts = regs_d[SPCR_IDX_TSCTL[2:0]];
    avl = regs_d[SPCR_IDX_ADDVAL_LO[2:0]];
    avh = regs_d[SPCR_IDX_ADDVAL_HI[2:0]];
    hb_d = regs_d[SPCR_IDX_HOSTBLK[2:0]]; // RULE_03
    // values above eleven are software's fault; passed unchanged
    av_d = {avh[28:24], avh[20:16], avh[12:8], avh[4:0],
            avl[28:24], avl[20:16], avl[12:8], avl[4:0]}; // RULE_04
    rx_d.msg_kind_en = ts[SPCR_TS_MSG_LSB +: 16]; // RULE_08
    tx_d.msg_kind_en = ts[SPCR_TS_MSG_LSB +: 16]; // RULE_08
    rx_d.annex_e = ts[SPCR_TS_RX_ANNEX_E]; // RULE_09
    rx_d.annex_d = ts[SPCR_TS_RX_ANNEX_D]; // RULE_09
    rx_d.vlan_type2 = ts[SPCR_TS_RX_VLAN2]; // RULE_09
    rx_d.vlan_type1 = ts[SPCR_TS_RX_VLAN1]; // RULE_09
    rx_d.annex_f = ts[SPCR_TS_RX_ANNEX_F]; // RULE_09
    tx_d.annex_e = ts[SPCR_TS_TX_ANNEX_E]; // RULE_10
    tx_d.annex_d = ts[SPCR_TS_TX_ANNEX_D]; // RULE_10
    tx_d.vlan_type2 = ts[SPCR_TS_TX_VLAN2]; // RULE_10
    tx_d.vlan_type1 = ts[SPCR_TS_TX_VLAN1]; // RULE_10
    tx_d.annex_f = ts[SPCR_TS_TX_ANNEX_F]; // RULE_10
    rx_d.second_length_type = ts[SPCR_TS_LT2]; // RULE_11
    tx_d.second_length_type = ts[SPCR_TS_LT2]; // RULE_11
    hts_d = ts[SPCR_TS_HOST_STAMP]; // RULE_12
  end

  // fed from next values so outputs track the registers with no extra lag
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hb_q <= 32'h00000000;
      av_q <= 40'h0000000000;
      rx_q <= '0;
      tx_q <= '0;
      hts_q <= 1'b0;
    end else begin
      hb_q <= hb_d;
      av_q <= av_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      hts_q <= hts_d;
    end
  end
  assign host_block_count_prio = hb_q;
  assign outflow_increment_prio = av_q;
  assign ts_rx = rx_q;
  assign ts_tx = tx_q;
  assign tx_host_stamp_enable = hts_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_SRCID_LOOKUP: assert property (@(posedge clk_sys) disable iff (srst) // RULE_01
    rx_in.valid |=> packet_source_identifier_valid &&
      packet_source_identifier == $past(ids_all[rx_in.port_idx*8 +: 8]))
    else $error("source id not taken from the port byte");
  AST_SRCID_RESET: assert property (@(posedge clk_sys) // RULE_02
    $past(srst) |-> regs_q[0] == 32'h04030201 && regs_q[1] == 32'h08070605)
    else $error("source ids did not reset to port numbers");
  AST_HOSTBLK_WRITE: assert property (@(posedge clk_sys) disable iff (srst) // RULE_03
    req.wr && req.addr == 6'h08 |=> host_block_count_prio == $past(req.wdata))
    else $error("host block counts not written");
  AST_PAUSE_ONLY: assert property (@(posedge clk_sys) disable iff (srst) // RULE_05
    !pause_out.valid |-> pause_out.src_addr == 48'h000000000000)
    else $error("pause address leaked outside pause frame");
  AST_PAUSE_LOW: assert property (@(posedge clk_sys) disable iff (srst) // RULE_06
    pause_frame_slot |=> pause_out.src_addr[7:0] == $past(plo[15:8]) &&
      pause_out.src_addr[15:8] == $past(plo[7:0]))
    else $error("pause low bytes misplaced");
  AST_PAUSE_HIGH: assert property (@(posedge clk_sys) disable iff (srst) // RULE_07
    pause_frame_slot |=> pause_out.src_addr[47:16] ==
      {$past(phi[7:0]), $past(phi[15:8]), $past(phi[23:16]), $past(phi[31:24])})
    else $error("pause high bytes misplaced");
  AST_MSG_BOTH: assert property (@(posedge clk_sys) disable iff (srst) // RULE_08
    ts_rx.msg_kind_en == ts_tx.msg_kind_en && ts_rx.msg_kind_en == regs_q[7][31:16])
    else $error("message kind enables differ by direction");
  AST_RX_BITS: assert property (@(posedge clk_sys) disable iff (srst) // RULE_09
    {ts_rx.annex_e, ts_rx.annex_d, ts_rx.vlan_type2, ts_rx.vlan_type1, ts_rx.annex_f}
      == {regs_q[7][9], regs_q[7][3:0]})
    else $error("rx decode enables misplaced");
  AST_TX_BITS: assert property (@(posedge clk_sys) disable iff (srst) // RULE_10
    {ts_tx.annex_e, ts_tx.annex_d, ts_tx.vlan_type2, ts_tx.vlan_type1, ts_tx.annex_f}
      == {regs_q[7][10], regs_q[7][7:4]})
    else $error("tx decode enables misplaced");
  AST_LT2_SHARED: assert property (@(posedge clk_sys) disable iff (srst) // RULE_11
    ts_rx.second_length_type == regs_q[7][8] && ts_tx.second_length_type == regs_q[7][8])
    else $error("second length type enable not shared");
  AST_HOST_STAMP: assert property (@(posedge clk_sys) disable iff (srst) // RULE_12
    tx_host_stamp_enable == regs_q[7][11])
    else $error("host stamp enable not at bit 11");
  AST_RESERVED: assert property (@(posedge clk_sys) disable iff (srst) // RULE_13
    ((regs_q[3] | regs_q[4]) & ~32'h1F1F1F1F) == 32'h00000000 &&
      regs_q[5][31:16] == 16'h0000 &&
      regs_q[7][15:12] == 4'h0)
    else $error("reserved bits not zero");

endmodule : spcr_regs

// File: tb.sv
// tb: self-checking bench for the switch port config register bank
// assumes spcr_pkg and spcr_regs compiled first; one 40 MHz clock, sync reset
`timescale 1ns/1ps
module tb;
  import spcr_pkg::*;
  logic clk_sys, srst, live, pause_frame_slot, exp_sv, exp_pv;
  logic packet_source_identifier_valid, tx_host_stamp_enable;
  spcr_req_s req;
  spcr_rx_s rx_in;
  spcr_pause_s pause_out;
  spcr_ts_dir_s ts_rx, ts_tx;
  logic [31:0] rdata, host_block_count_prio, exp_rd, seed;
  logic [7:0] packet_source_identifier, exp_sid;
  logic [39:0] outflow_increment_prio;
  logic [47:0] exp_pa;
  logic [31:0] mdl [8];
  logic [31:0] msk [8];
  int miscompares, tests_run;

  spcr_regs i_spcr_regs (.clk_sys(clk_sys), .srst(srst), .req(req), .rdata(rdata),
    .rx_in(rx_in), .packet_source_identifier(packet_source_identifier),
    .packet_source_identifier_valid(packet_source_identifier_valid),
    .pause_frame_slot(pause_frame_slot), .pause_out(pause_out),
    .host_block_count_prio(host_block_count_prio),
    .outflow_increment_prio(outflow_increment_prio), .ts_rx(ts_rx), .ts_tx(ts_tx),
    .tx_host_stamp_enable(tx_host_stamp_enable));

  ////////////////////////////////////////////////////////////////////////////////
  // reference model
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // port k resets to k, four ports to a word, low port in the low byte
  task automatic mdl_reset();
    for (int k = 0; k < 8; k++) mdl[k] = 32'h0;
    for (int k = 1; k <= 8; k++) mdl[(k-1)/4][8*((k-1)%4)+:8] = k[7:0];
  endtask : mdl_reset

  // unmapped or unaligned places read zero
  function automatic logic [31:0] rdm(logic [5:0] a);
    return (a[1:0] == 2'h0 && a < 6'h20) ? mdl[a[4:2]] : 32'h0;
  endfunction : rdm

  function automatic logic [39:0] ofl();
    logic [39:0] o;
    for (int p = 0; p < 8; p++) o[5*p+:5] = mdl[3+p/4][8*(p%4)+:5];
    return o;
  endfunction : ofl

  // byte0 sits in the low word's upper byte, byte5 in the high word's low byte
  function automatic logic [47:0] pa();
    return {mdl[6][7:0], mdl[6][15:8], mdl[6][23:16], mdl[6][31:24], mdl[5][7:0],
      mdl[5][15:8]};
  endfunction : pa

  task automatic chk(input string n, input logic [48:0] e, input logic [48:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic conclude();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////////
  // register port tasks, called right after a rising edge
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] v;
    v = d;
    // software keeps every add value at eleven or below
    if (a[4:2] == 3'h3 || a[4:2] == 3'h4) begin
      for (int b = 0; b < 4; b++) begin
        if (v[8*b+:5] > SPCR_ADDVAL_MAX) v[8*b+:5] = SPCR_ADDVAL_MAX;
      end
    end
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk_sys);
    req.wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [5:0] a);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    @(posedge clk_sys);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////////
  // expected results, one cycle behind their causes
  always @(posedge clk_sys) begin
    // model words move at the same edge as the bank; reserved bits dropped
    if (req.wr && !srst && req.addr[1:0] == 2'h0 && req.addr < 6'h20) begin
      mdl[req.addr[4:2]] <= req.wdata & msk[req.addr[4:2]];
    end
    exp_pa <= pa();
    exp_rd <= (req.rd && !srst) ? rdm(req.addr) : 32'h0;
    exp_sv <= rx_in.valid && !srst;
    exp_sid <= mdl[rx_in.port_idx[2]][8*rx_in.port_idx[1:0]+:8];
    exp_pv <= pause_frame_slot && !srst;
  end

  // compare every result mid-cycle, when all edges have settled
  always @(negedge clk_sys) begin
    if (live) begin
      chk("rdata", 49'(exp_rd), 49'(rdata));
      chk("sid_valid", 49'(exp_sv), 49'(packet_source_identifier_valid));
      if (exp_sv) chk("sid", 49'(exp_sid), 49'(packet_source_identifier));
      chk("pause", {exp_pv, exp_pv ? exp_pa : 48'h0}, 49'(pause_out));
      chk("host_blocks", 49'(mdl[2]), 49'(host_block_count_prio));
      chk("outflow", 49'(ofl()), 49'(outflow_increment_prio));
      chk("ts_rx", 49'({mdl[7][31:16], mdl[7][9], mdl[7][3:0], mdl[7][8]}), 49'(ts_rx));
      chk("ts_tx", 49'({mdl[7][31:16], mdl[7][10], mdl[7][7:4], mdl[7][8]}), 49'(ts_tx));
      chk("host_stamp", 49'(mdl[7][11]), 49'(tx_host_stamp_enable));
    end
  end

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // hang guard, far above the planned run length
  initial begin
    #250000;
    miscompares++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] r;
    msk = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h1F1F1F1F, 32'h1F1F1F1F,
      32'h0000FFFF, 32'hFFFFFFFF, 32'hFFFF0FFF};
    seed = 32'hB37C;
    miscompares = 0;
    tests_run = 0;
    live = 1'b0;
    srst = 1'b1;
    req = '0;
    rx_in = '0;
    pause_frame_slot = 1'b0;
    mdl_reset();
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    live <= 1'b1;
    @(posedge clk_sys);
    // reset values of every word, then all ones and all zeros
    for (int i = 0; i < 8; i++) rd(6'(4*i));
    for (int i = 0; i < 8; i++) wr(6'(4*i), 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++) rd(6'(4*i));
    for (int i = 0; i < 8; i++) wr(6'(4*i), 32'h0);
    // largest legal add value in every priority
    wr(6'h0C, 32'h0B0B0B0B);
    wr(6'h10, 32'h0B0B0B0B);
    rd(6'h10);
    // random accesses, unaligned and unmapped places among them
    for (int n = 0; n < 400; n++) begin
      r = rnd();
      if (r[6]) wr(r[5:0], rnd());
      else rd(r[5:0]);
    end
    // back-to-back frames and pause slots on random ports
    for (int n = 0; n < 200; n++) begin
      r = rnd();
      rx_in <= '{valid: r[0], port_idx: r[3:1]};
      pause_frame_slot <= r[4];
      @(posedge clk_sys);
      if (n % 50 == 49) wr(6'h18, rnd());
    end
    rx_in <= '0;
    pause_frame_slot <= 1'b0;
    @(posedge clk_sys);
    // second reset in mid-run brings back the reset values
    live <= 1'b0;
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    mdl_reset();
    @(posedge clk_sys);
    live <= 1'b1;
    for (int i = 0; i < 8; i++) rd(6'(4*i));
    repeat (2) @(posedge clk_sys);
    conclude();
  end
endmodule : tb
